// ---- pkg/adcp_defs.svh ----
// Constants for the converter output pipeline model
`ifndef ADCP_DEFS_SVH
`define ADCP_DEFS_SVH

`define ADCP_CODE_W        8
`define ADCP_IN_W          10
`define ADCP_LATENCY       6
`define ADCP_CODE_ZERO     8'h00
`define ADCP_CODE_FULL     8'hFF
`define ADCP_CLK_PERIOD_PS 25000
`define ADCP_WAKE_NS       1000
`define ADCP_WAKE_CYC      ((`ADCP_WAKE_NS * 1000 + `ADCP_CLK_PERIOD_PS - 1) / `ADCP_CLK_PERIOD_PS)

`endif

// ---- pkg/adcp_pkg.sv ----
// Types for the converter output pipeline model
`default_nettype none
`include "adcp_defs.svh"

package adcp_pkg;
   typedef logic [`ADCP_CODE_W-1:0] adcp_code_t;

   typedef enum logic [2:0] {
      ADCP_ST_RUN   = 3'b001,
      ADCP_ST_SLEEP = 3'b010,
      ADCP_ST_WAKE  = 3'b100
   } adcp_state_t;
endpackage : adcp_pkg

`default_nettype wire

// ---- hw/adcp_quant.sv ----
// Combinational quantiser of one sampled level against the ladder
`timescale 1ns/1ps
`default_nettype none
`include "adcp_defs.svh"

module adcp_quant #(
   parameter int IN_W = `ADCP_IN_W
) (
   input  wire logic [IN_W-1:0]     level_in,
   input  wire logic [IN_W-1:0]     top_in,
   input  wire logic [IN_W-1:0]     bot_in,
   output var  adcp_pkg::adcp_code_t code_out
);
   import adcp_pkg::*;

   localparam int W = `ADCP_CODE_W;

   logic [IN_W-1:0]   diff;
   logic [IN_W-1:0]   span;
   logic [IN_W+W-1:0] num;
   logic [IN_W+W-1:0] quo;

   assign diff = level_in - bot_in;
   assign span = top_in - bot_in;
   // Scale by full code with rounding to nearest step
   assign num  = ({{W{1'b0}}, diff} << W) - {{W{1'b0}}, diff}
               + {{(W+1){1'b0}}, span[IN_W-1:1]};
   assign quo  = (span == '0) ? '0 : num / {{W{1'b0}}, span};

   always_comb begin
      if (level_in < bot_in) begin
         code_out = `ADCP_CODE_ZERO;
      end else if (level_in > top_in) begin
         code_out = `ADCP_CODE_FULL;
      end else if (top_in <= bot_in) begin
         // Collapsed ladder: no usable span
         code_out = `ADCP_CODE_ZERO;
      end else begin
         code_out = quo[W-1:0];
      end
   end
endmodule : adcp_quant

`default_nettype wire

// ---- hw/adcp_top.sv ----
// Output pipeline model of an 8-bit sampling converter
// Notes on behaviour
// - In-range input quantised to eight bit code
// - Input below bottom reference gives all zeros
// - Input above top reference gives all ones
// - Code appears six clocks after capture edge
// - One conversion per clock while clock runs and not asleep
// - Straight binary, bottom zero, top full code
// - Converts only while sleep request is low
// - Sleep holds last converted code on bus
// - Stopped clock keeps last code on bus
`timescale 1ns/1ps
`default_nettype none
`include "adcp_defs.svh"

module adcp_top #(
   parameter int IN_W     = `ADCP_IN_W,
   parameter int LATENCY  = `ADCP_LATENCY,
   parameter int WAKE_CYC = `ADCP_WAKE_CYC
) (
   input  wire logic                  ref_clk_in,
   input  wire logic                  resetn_in,
   input  wire logic                  clk_en_in,
   input  wire logic [IN_W-1:0]       analog_in,
   input  wire logic [IN_W-1:0]       ladder_top_reference_in,
   input  wire logic [IN_W-1:0]       ladder_bottom_reference_in,
   input  wire logic                  sleep_request_in,
   output var  adcp_pkg::adcp_code_t  code_out,
   output logic                       code_valid_out,
   output logic                       low_power_out
);
   import adcp_pkg::*;

   localparam int NSTG  = LATENCY - 1;
   localparam int CNT_W = $clog2(WAKE_CYC + 1);
   localparam int RF_W  = $clog2(NSTG + 1);

   logic [IN_W-1:0] lvl_s1_q;
   logic [IN_W-1:0] lvl_s2_q;
   logic [IN_W-1:0] top_s1_q;
   logic [IN_W-1:0] top_s2_q;
   logic [IN_W-1:0] bot_s1_q;
   logic [IN_W-1:0] bot_s2_q;
   logic            slp_s1_q;
   logic            slp_s2_q;
   logic            run;
   adcp_code_t      code_c;
   adcp_code_t      pipe_q [0:NSTG-1];
   logic [NSTG-1:0] vld_q;
   adcp_state_t     st_q;
   adcp_state_t     st_d;
   logic [CNT_W-1:0] cnt_q;
   logic [RF_W-1:0]  refill_q;

   // Capture edge doubles as first synchroniser stage for pin levels
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         lvl_s1_q <= '0;
         lvl_s2_q <= '0;
         top_s1_q <= '0;
         top_s2_q <= '0;
         bot_s1_q <= '0;
         bot_s2_q <= '0;
      end else if (clk_en_in) begin
         lvl_s1_q <= analog_in;
         lvl_s2_q <= lvl_s1_q;
         top_s1_q <= ladder_top_reference_in;
         top_s2_q <= top_s1_q;
         bot_s1_q <= ladder_bottom_reference_in;
         bot_s2_q <= bot_s1_q;
      end
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         slp_s1_q <= 1'b0;
         slp_s2_q <= 1'b0;
      end else if (clk_en_in) begin
         slp_s1_q <= sleep_request_in;
         slp_s2_q <= slp_s1_q;
      end
   end

   // Sleep takes effect two clocks after the pin rises, so the held
   // code is the last one finished before the synchronised request
   assign run = clk_en_in & ~slp_s2_q;

   adcp_quant #(
      .IN_W (IN_W)
   ) u_quant (
      .level_in (lvl_s2_q),
      .top_in   (top_s2_q),
      .bot_in   (bot_s2_q),
      .code_out (code_c)
   );

   generate
      for (genvar i = 0; i < NSTG; i++) begin : g_stage
         always_ff @(posedge ref_clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
               pipe_q[i] <= `ADCP_CODE_ZERO;
            end else if (run) begin
               pipe_q[i] <= (i == 0) ? code_c : pipe_q[(i == 0) ? 0 : i-1];
            end
         end

         always_ff @(posedge ref_clk_in or negedge resetn_in) begin
            if (!resetn_in) begin
               vld_q[i] <= 1'b0;
            end else if (clk_en_in && slp_s2_q) begin
               // Sleep wipes every stage so stale words never pass as valid
               vld_q[i] <= 1'b0;
            end else if (run) begin
               vld_q[i] <= (i == 0) ? (st_q == ADCP_ST_RUN) : vld_q[(i == 0) ? 0 : i-1];
            end
         end
      end
   endgenerate

   // Power state; wake hold covers the settling time after sleep
   always_comb begin
      st_d = st_q;
      case (st_q)
         ADCP_ST_RUN: begin
            if (slp_s2_q) st_d = ADCP_ST_SLEEP;
         end
         ADCP_ST_SLEEP: begin
            if (!slp_s2_q) st_d = ADCP_ST_WAKE;
         end
         ADCP_ST_WAKE: begin
            if (slp_s2_q) begin
               st_d = ADCP_ST_SLEEP;
            end else if (cnt_q == '0) begin
               st_d = ADCP_ST_RUN;
            end
         end
         default: st_d = ADCP_ST_RUN;
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         // Sync stages hold stale levels after reset; a short wake
         // hold keeps those from being flagged as converted codes
         st_q <= ADCP_ST_WAKE;
      end else if (clk_en_in) begin
         st_q <= st_d;
      end
   end

   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cnt_q <= CNT_W'(1);
      end else if (clk_en_in) begin
         if (st_q == ADCP_ST_SLEEP) begin
            cnt_q <= CNT_W'(WAKE_CYC - 1);
         end else if (st_q == ADCP_ST_WAKE && cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

   // Run edges since entering run, saturating at the stage count
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         refill_q <= '0;
      end else if (clk_en_in) begin
         if (st_q != ADCP_ST_RUN) begin
            refill_q <= '0;
         end else if (run && refill_q != RF_W'(NSTG)) begin
            refill_q <= refill_q + 1'b1;
         end
      end
   end

   assign code_out       = pipe_q[NSTG-1];
   assign code_valid_out = vld_q[NSTG-1];
   assign low_power_out  = (st_q == ADCP_ST_SLEEP);

   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);

   // Quantiser checks look at the synchronised levels, not the pins
   lat_six_a: assert property (run [*5] |=> code_out == $past(code_c, 5))
      else $error("code did not reach bus after six clocks");
   sat_low_a: assert property (lvl_s2_q < bot_s2_q |-> code_c == `ADCP_CODE_ZERO)
      else $error("below-range input not all zeros");
   sat_high_a: assert property (lvl_s2_q > top_s2_q |-> code_c == `ADCP_CODE_FULL)
      else $error("above-range input not all ones");
   bin_ends_a: assert property (top_s2_q > bot_s2_q
      |-> (lvl_s2_q == bot_s2_q) == (code_c == `ADCP_CODE_ZERO && lvl_s2_q == bot_s2_q)
          && (lvl_s2_q != top_s2_q || code_c == `ADCP_CODE_FULL))
      else $error("range ends not zero and full code");
   hold_sleep_a: assert property (slp_s2_q |=> $stable(code_out))
      else $error("bus moved while asleep");
   hold_stop_a: assert property (!clk_en_in |=> $stable(code_out) && $stable(code_valid_out))
      else $error("bus moved with clock stopped");
   wake_refill_a: assert property ($fell(slp_s2_q) |-> !code_valid_out [*6])
      else $error("valid flagged before refill");
   conv_rate_a: assert property (code_valid_out && run |=> code_valid_out)
      else $error("continuous conversion lost valid");
   sleep_enter_a: assert property (clk_en_in && slp_s2_q
      |=> low_power_out && !code_valid_out)
      else $error("sleep did not enter low power");
   awake_power_a: assert property (clk_en_in && !slp_s2_q |=> !low_power_out)
      else $error("low power shown while awake");
   wake_gate_a: assert property (st_q != ADCP_ST_RUN |-> !code_valid_out)
      else $error("valid flagged outside run state");
   wake_hold_a: assert property (clk_en_in && !slp_s2_q && st_q == ADCP_ST_WAKE
      && cnt_q != '0 |=> st_q == ADCP_ST_WAKE)
      else $error("wake hold cut short");
   run_valid_a: assert property ((st_q == ADCP_ST_RUN && run) [*6] |=> code_valid_out)
      else $error("valid missing in steady conversion");
   refill_count_a: assert property (code_valid_out |-> refill_q == RF_W'(NSTG))
      else $error("valid flagged before pipeline refilled");

   cover_high_c:  cover property (lvl_s2_q > top_s2_q ##1 run [*5]);
   cover_low_c:   cover property (lvl_s2_q < bot_s2_q ##1 run [*5]);
   cover_sleep_c: cover property (code_valid_out ##1 slp_s2_q [*3] ##1 !slp_s2_q);
   cover_wake_c:  cover property (st_q == ADCP_ST_WAKE ##1 st_q == ADCP_ST_RUN);
   cover_stop_c:  cover property (!clk_en_in ##1 !clk_en_in ##1 clk_en_in);
endmodule : adcp_top

`default_nettype wire

// ---- tb/adcp_capture.sv ----
// Far-side capture logic that collects sample words from the bus
`timescale 1ns/1ps
`default_nettype none

module adcp_capture #(
   parameter int GUARD = 40
) (
   input  wire logic                 ref_clk_in,
   input  wire logic                 resetn_in,
   input  wire logic                 sleep_request_in,
   input  wire adcp_pkg::adcp_code_t code_in,
   input  wire logic                 code_valid_in,
   output var adcp_pkg::adcp_code_t  word_out,
   output logic [15:0]               count_out
);
   import adcp_pkg::*;
   int guard_q;

   // Clock always runs here, so words keep coming
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         guard_q <= 0;
      end else if (sleep_request_in) begin
         guard_q <= GUARD;
      end else if (guard_q != 0) begin
         guard_q <= guard_q - 1;
      end
   end

   // Codes just after wake are not trusted, even if flagged
   always_ff @(posedge ref_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         word_out  <= 8'h00;
         count_out <= 16'h0000;
      end else if (code_valid_in && guard_q == 0 && !sleep_request_in) begin
         word_out  <= code_in;
         count_out <= count_out + 16'h0001;
      end
   end
endmodule : adcp_capture

`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the converter output pipeline
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import adcp_pkg::*;
   logic        ref_clk_in, resetn_in, clk_en_in, sleep_request_in;
   logic [9:0]  analog_in, top_lvl, bot_lvl;
   adcp_code_t  code_out, word;
   logic        code_valid_out, low_power_out;
   logic [15:0] n_cap;
   int          n_mismatch = 0;
   int          checked = 0;

   adcp_top #(.WAKE_CYC(2)) uut (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
      .clk_en_in(clk_en_in), .analog_in(analog_in), .ladder_top_reference_in(top_lvl),
      .ladder_bottom_reference_in(bot_lvl), .sleep_request_in(sleep_request_in),
      .code_out(code_out), .code_valid_out(code_valid_out), .low_power_out(low_power_out));
   adcp_capture cap (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
      .sleep_request_in(sleep_request_in), .code_in(code_out),
      .code_valid_in(code_valid_out), .word_out(word), .count_out(n_cap));

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic close_out;
      if (n_mismatch == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : close_out

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_in);
      #1;
   endtask : cyc

   // Bounded wait: 0 waits for low power, 1 for a valid code
   task automatic wait_for(input int which, output int k);
      for (k = 0; k < 200; k++) begin
         if (which == 0 ? low_power_out === 1'b1 : code_valid_out === 1'b1) break;
         cyc(1);
      end
      if (k == 200) begin
         n_mismatch++;
         close_out();
      end
   endtask : wait_for

   // Ladder 100..1FF gives one code per level
   task automatic t_stream;
      logic [9:0] v [8] = '{10'h000, 10'h3FF, 10'h100, 10'h1FF, 10'h150, 10'h0FF, 10'h200, 10'h1AB};
      logic [7:0] e [8] = '{8'h00, 8'hFF, 8'h00, 8'hFF, 8'h50, 8'h00, 8'hFF, 8'hAB};
      for (int j = 0; j < 15; j++) begin
         if (j < 8) analog_in = v[j];
         if (j >= 7) check("code", code_out, e[j-7]);
         if (j >= 7) check("valid", code_valid_out, 1'b1);
         cyc(1);
      end
      check("captured", word, 8'hAB);
   endtask : t_stream

   task automatic t_sleep;
      int k;
      logic [15:0] n0;
      analog_in = 10'h150;
      cyc(10);
      sleep_request_in = 1'b1;
      n0 = n_cap;
      analog_in = 10'h180;
      wait_for(0, k);
      check("valid asleep", code_valid_out, 1'b0);
      cyc(10);
      check("held code", code_out, 8'h50);
      sleep_request_in = 1'b0;
      wait_for(1, k);
      check("refill", k >= 6, 1'b1);
      check("woken code", code_out, 8'h80);
      check("low power", low_power_out, 1'b0);
      check("guarded", n_cap, n0);
   endtask : t_sleep

   task automatic t_stop;
      analog_in = 10'h1AB;
      cyc(10);
      clk_en_in = 1'b0;
      analog_in = 10'h100;
      cyc(10);
      check("stopped", code_out, 8'hAB);
      clk_en_in = 1'b1;
      cyc(8);
      check("restart", code_out, 8'h00);
   endtask : t_stop

   initial begin
      ref_clk_in = 1'b0;
      forever #12.5 ref_clk_in = ~ref_clk_in;
   end

   initial begin
      resetn_in = 1'b0;
      clk_en_in = 1'b1;
      sleep_request_in = 1'b0;
      analog_in = 10'h000;
      top_lvl = 10'h1FF;
      bot_lvl = 10'h100;
      cyc(5);
      check("reset code", {code_valid_out, low_power_out, code_out}, 10'h000);
      resetn_in = 1'b1;
      cyc(6);
      check("early valid", code_valid_out, 1'b0);
      cyc(1);
      check("first code", {code_valid_out, code_out}, 9'h100);
      cyc(3);
      t_stream();
      t_sleep();
      t_stop();
      close_out();
   end
endmodule : testbench

`default_nettype wire
